// ===== logic/paafo_pkg.sv
// Purpose: constants for the port A alternate-function override block
// Assumes: one 200 MHz system clock, synchronous active-high reset
// Notes: pin indices, reset values and spike filter timing live here
//
// Summary of operation
// [R1] two-wire enable turns pin 7 into open-drain clock
// [R2] two-wire enable activates slew limit and spike filter
// [R3] SPI slave forces pin 7 to input unless two-wire is enabled
// [R4] SPI slave forces pin 6 to input
// [R5] compare B reaches pin 7 only as output
// [R6] pin 7 input feeds timer 1 capture and clock
// [R7] each pin n is pin-change source n
// [R8] pin 7 value override on two-wire, master, compare
// [R9] pin 7 override value from two-wire, SPI clock, compare
// [R10] input override: mask and enable, or ADC disable
// [R11] pin 7 input to timer, SPI, two-wire, pin-change
// [R12] pin 6 input to slave select and pin-change
// [R13] direction override value else direction register bit
// [R14] value override value else output register bit, zero when not driving
// [R15] input-enable override value else processor state decides
// [R16] pull-up override value else pull-up register bit
// [R17] pins 0 to 5 override only input enable
package paafo_pkg;
    localparam int PIN_COUNT = 8;
    localparam int PIN_SS = 6;
    localparam int PIN_SCK = 7;
    localparam logic [7:0] RESET_PIN_VEC = 8'h00;
    localparam logic RESET_BIT = 1'b0;
    // spike suppression on the two-wire clock input
    localparam int CLK_PERIOD_PS = 5000;
    localparam int SPIKE_WIDTH_PS = 50000;
    localparam int SPIKE_CYCLES = (SPIKE_WIDTH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SPIKE_CNT_W = 4;
    localparam logic [SPIKE_CNT_W-1:0] SPIKE_CNT_RESET = 4'h0;
endpackage : paafo_pkg

// ===== logic/paafo_sync.sv
// Purpose: two-stage synchroniser for pad inputs
// Assumes: inputs asynchronous to i_clk
// Notes: first stage is read only by the second stage
`timescale 1ns/100ps
module paafo_sync #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // data
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    always_comb begin
        meta_next = i_async;
        sync_next = meta_reg;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign o_sync = sync_reg;
endmodule : paafo_sync

// ===== logic/paafo_port_a.sv
// Purpose: alternate-function override of the 8-bit port A pad logic
// Assumes: control bits arrive on i_clk; pad inputs are asynchronous
// Notes: all pad and peripheral data outputs are registered
`timescale 1ns/100ps
module paafo_port_a (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // port registers and processor state
    input wire logic [7:0] i_port_dir,
    input wire logic [7:0] i_port_out,
    input wire logic [7:0] i_pullup_en,
    input wire logic i_mcu_input_en,
    // pin-change and ADC settings
    input wire logic [7:0] i_pin_change_mask,
    input wire logic i_pin_change_group0_enable,
    input wire logic [7:0] i_adc_input_disable,
    // peripheral controls and outputs
    input wire logic i_two_wire_enable,
    input wire logic i_two_wire_clock_out,
    input wire logic i_spi_enable_bit,
    input wire logic i_spi_master_select,
    input wire logic i_spi_clock_out,
    input wire logic i_timer0_compare_b_out,
    input wire logic i_timer0_compare_b_pin_en,
    // pad side
    input wire logic [7:0] i_pad_in,
    output logic [7:0] o_pad_out,
    output logic [7:0] o_pad_oe,
    output logic [7:0] o_pad_pullup,
    output logic [7:0] o_pad_input_en,
    output logic o_pin7_slew_limit_en,
    output logic o_pin7_spike_filter_en,
    // peripheral inputs
    output logic o_timer1_capture_in,
    output logic o_timer1_ext_clock_in,
    output logic o_spi_clock_in,
    output logic o_spi_slave_select_in,
    output logic o_two_wire_clock_in,
    output logic [7:0] o_pin_change_src
);
    // select override or normal value per bit
    function automatic logic [7:0] ovr_mux(input logic [7:0] en, input logic [7:0] val,
                                           input logic [7:0] norm);
        ovr_mux = (en & val) | (~en & norm);
    endfunction : ovr_mux

    logic [7:0] pad_sync;
    logic spi_master;
    logic spi_slave;
    logic [7:0] pullup_ovr_en;
    logic [7:0] pullup_ovr_val;
    logic [7:0] direction_ovr_en;
    logic [7:0] direction_ovr_val;
    logic [7:0] value_ovr_en;
    logic [7:0] value_ovr_val;
    logic [7:0] input_en_ovr_en;
    logic [7:0] input_en_ovr_val;
    logic [7:0] oe_comb;
    logic [7:0] input_en_comb;
    logic [7:0] di_comb;

    logic [7:0] pad_out_reg, pad_out_next;
    logic [7:0] pad_oe_reg, pad_oe_next;
    logic [7:0] pullup_reg, pullup_next;
    logic [7:0] input_en_reg, input_en_next;
    logic [7:0] pc_src_reg, pc_src_next;
    logic slew_reg, slew_next;
    logic filt_en_reg, filt_en_next;
    logic t1_cap_reg, t1_cap_next;
    logic t1_clk_reg, t1_clk_next;
    logic spi_clk_reg, spi_clk_next;
    logic spi_ss_reg, spi_ss_next;
    logic scl_filt_reg, scl_filt_next;
    logic [paafo_pkg::SPIKE_CNT_W-1:0] spike_cnt_reg, spike_cnt_next;

    paafo_sync #(
        .WIDTH(paafo_pkg::PIN_COUNT)
    ) u_pad_sync (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_async(i_pad_in),
        .o_sync(pad_sync)
    );

    assign spi_master = i_spi_enable_bit & i_spi_master_select;
    assign spi_slave = i_spi_enable_bit & ~i_spi_master_select;

    // override signal generation
    always_comb begin
        pullup_ovr_en = 8'h00; // R16
        pullup_ovr_val = 8'h00;
        direction_ovr_en = 8'h00; // R17
        direction_ovr_val = 8'h00;
        value_ovr_en = 8'h00; // R17
        value_ovr_val = 8'h00;
        // slave mode: forced input on select pin, and on clock pin unless two-wire is enabled
        direction_ovr_en[paafo_pkg::PIN_SS] = spi_slave; // R4
        direction_ovr_val[paafo_pkg::PIN_SS] = 1'b0;
        // open drain: drive low only while the two-wire clock is low
        direction_ovr_en[paafo_pkg::PIN_SCK] = i_two_wire_enable | spi_slave; // R1 R3
        direction_ovr_val[paafo_pkg::PIN_SCK] = i_two_wire_enable & ~i_two_wire_clock_out; // R1
        value_ovr_en[paafo_pkg::PIN_SCK] = i_two_wire_enable | spi_master
                                         | i_timer0_compare_b_pin_en; // R8
        value_ovr_val[paafo_pkg::PIN_SCK] = ~i_two_wire_enable
            & (spi_master ? i_spi_clock_out : i_timer0_compare_b_out); // R9
        input_en_ovr_val = i_pin_change_mask & {8{i_pin_change_group0_enable}}; // R10
        input_en_ovr_en = input_en_ovr_val | i_adc_input_disable; // R10
    end

    // pad muxing; compare B rides the direction register bit
    always_comb begin
        oe_comb = ovr_mux(direction_ovr_en, direction_ovr_val, i_port_dir); // R13 R5
        input_en_comb = ovr_mux(input_en_ovr_en, input_en_ovr_val,
                                {8{i_mcu_input_en}}); // R15
        di_comb = pad_sync & input_en_comb;
        pad_oe_next = oe_comb;
        pad_out_next = oe_comb & ovr_mux(value_ovr_en, value_ovr_val, i_port_out); // R14
        pullup_next = ovr_mux(pullup_ovr_en, pullup_ovr_val, i_pullup_en); // R16
        input_en_next = input_en_comb;
        pc_src_next = di_comb; // R7
        slew_next = i_two_wire_enable; // R2
        filt_en_next = i_two_wire_enable; // R2
        t1_cap_next = di_comb[paafo_pkg::PIN_SCK]; // R6 R11
        t1_clk_next = di_comb[paafo_pkg::PIN_SCK]; // R6 R11
        spi_clk_next = di_comb[paafo_pkg::PIN_SCK]; // R11
        spi_ss_next = di_comb[paafo_pkg::PIN_SS]; // R12
    end

    // spike filter on the two-wire clock input, bypassed when disabled
    always_comb begin
        spike_cnt_next = paafo_pkg::SPIKE_CNT_RESET;
        scl_filt_next = scl_filt_reg;
        if (!i_two_wire_enable) begin
            scl_filt_next = di_comb[paafo_pkg::PIN_SCK];
        end else if (di_comb[paafo_pkg::PIN_SCK] != scl_filt_reg) begin
            if (spike_cnt_reg == paafo_pkg::SPIKE_CNT_W'(paafo_pkg::SPIKE_CYCLES - 1)) begin
                scl_filt_next = di_comb[paafo_pkg::PIN_SCK]; // R2 R11
            end else begin
                spike_cnt_next = spike_cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            pad_out_reg <= paafo_pkg::RESET_PIN_VEC;
            pad_oe_reg <= paafo_pkg::RESET_PIN_VEC;
            pullup_reg <= paafo_pkg::RESET_PIN_VEC;
            input_en_reg <= paafo_pkg::RESET_PIN_VEC;
            pc_src_reg <= paafo_pkg::RESET_PIN_VEC;
            slew_reg <= paafo_pkg::RESET_BIT;
            filt_en_reg <= paafo_pkg::RESET_BIT;
            t1_cap_reg <= paafo_pkg::RESET_BIT;
            t1_clk_reg <= paafo_pkg::RESET_BIT;
            spi_clk_reg <= paafo_pkg::RESET_BIT;
            spi_ss_reg <= paafo_pkg::RESET_BIT;
            scl_filt_reg <= paafo_pkg::RESET_BIT;
            spike_cnt_reg <= paafo_pkg::SPIKE_CNT_RESET;
        end else begin
            pad_out_reg <= pad_out_next;
            pad_oe_reg <= pad_oe_next;
            pullup_reg <= pullup_next;
            input_en_reg <= input_en_next;
            pc_src_reg <= pc_src_next;
            slew_reg <= slew_next;
            filt_en_reg <= filt_en_next;
            t1_cap_reg <= t1_cap_next;
            t1_clk_reg <= t1_clk_next;
            spi_clk_reg <= spi_clk_next;
            spi_ss_reg <= spi_ss_next;
            scl_filt_reg <= scl_filt_next;
            spike_cnt_reg <= spike_cnt_next;
        end
    end

    assign o_pad_out = pad_out_reg;
    assign o_pad_oe = pad_oe_reg;
    assign o_pad_pullup = pullup_reg;
    assign o_pad_input_en = input_en_reg;
    assign o_pin_change_src = pc_src_reg;
    assign o_pin7_slew_limit_en = slew_reg;
    assign o_pin7_spike_filter_en = filt_en_reg;
    assign o_timer1_capture_in = t1_cap_reg;
    assign o_timer1_ext_clock_in = t1_clk_reg;
    assign o_spi_clock_in = spi_clk_reg;
    assign o_spi_slave_select_in = spi_ss_reg;
    assign o_two_wire_clock_in = scl_filt_reg;
endmodule : paafo_port_a

// ===== bench/paafo_properties.sv
// Purpose: properties of the port A override block
// Assumes: one clock, synchronous reset
// Notes: bound to every paafo_port_a
`timescale 1ns/100ps
module paafo_properties (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // controls
    input wire logic [7:0] i_port_dir,
    input wire logic i_two_wire_enable,
    input wire logic i_two_wire_clock_out,
    input wire logic i_spi_enable_bit,
    input wire logic i_spi_master_select,
    input wire logic i_spi_clock_out,
    // outputs
    input wire logic [7:0] o_pad_out,
    input wire logic [7:0] o_pad_oe,
    input wire logic [7:0] o_pad_input_en,
    input wire logic [7:0] o_pin_change_src,
    input wire logic o_pin7_slew_limit_en,
    input wire logic o_pin7_spike_filter_en,
    input wire logic o_timer1_capture_in,
    input wire logic o_timer1_ext_clock_in,
    input wire logic o_spi_clock_in,
    input wire logic o_spi_slave_select_in
);
    wire logic master = i_spi_enable_bit & i_spi_master_select;
    wire logic slave = i_spi_enable_bit & ~i_spi_master_select;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    a_scl_open_drain: assert property (
        i_two_wire_enable |=> !o_pad_out[7] && o_pad_oe[7] == !$past(i_two_wire_clock_out))
        else $error("pin 7 clock drive wrong");
    a_filter_follows: assert property (
        $changed(i_two_wire_enable) |=> o_pin7_spike_filter_en == $past(i_two_wire_enable)
        && o_pin7_slew_limit_en == $past(i_two_wire_enable)) else $error("filter enable wrong");
    a_slave_pins_in: assert property (slave && !i_two_wire_enable |=> o_pad_oe[7:6] == 2'h0)
        else $error("slave pins driven");
    a_compare_dir: assert property (!i_two_wire_enable && !i_port_dir[7] |=> !o_pad_oe[7])
        else $error("pin 7 driven without direction");
    a_master_clock: assert property (
        !i_two_wire_enable && master && i_port_dir[7] |=> o_pad_oe[7]
        && o_pad_out[7] == $past(i_spi_clock_out)) else $error("master clock missing");
    a_low_pins_plain: assert property (
        1'b1 |=> o_pad_oe[5:0] == $past(i_port_dir[5:0])) else $error("low pins overridden");
    a_pin7_inputs_tied: assert property (
        o_timer1_capture_in == o_timer1_ext_clock_in && o_spi_clock_in == o_pin_change_src[7]
        && o_timer1_capture_in == o_spi_clock_in) else $error("pin 7 inputs differ");
    a_ss_gated_low: assert property (
        !o_pad_input_en[6] [*4] |-> !o_spi_slave_select_in && !o_pin_change_src[6])
        else $error("disabled pin 6 input seen");
    c_two_wire: cover property (i_two_wire_enable && !i_two_wire_clock_out);
    c_slave: cover property (slave);
    c_master: cover property (master && i_port_dir[7]);
endmodule : paafo_properties
bind paafo_port_a paafo_properties u_props (.*);

// ===== bench/paafo_periph_model.sv
// Purpose: model of the peripherals that drive pin 7
// Assumes: bench picks the next levels
// Notes: levels move on the rising edge
`timescale 1ns/100ps
module paafo_periph_model (
    // clock
    input wire logic i_clk,
    // next levels: two-wire clock, spi clock, compare b
    input wire logic [2:0] i_val,
    // present levels
    output logic [2:0] o_levels = 3'h0
);
    always @(posedge i_clk) begin
        o_levels <= i_val;
    end
endmodule : paafo_periph_model

// ===== bench/paafo_port_a_bench.sv
// Purpose: random and directed bench for paafo_port_a
// Assumes: inputs change on the falling edge
// Notes: each random setting is held until outputs settle
`timescale 1ns/100ps
module paafo_port_a_bench;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [7:0] i_port_dir, i_port_out, i_pullup_en, i_pad_in, i_pin_change_mask;
    logic [7:0] i_adc_input_disable, o_pad_out, o_pad_oe, o_pad_pullup, o_pad_input_en;
    logic [7:0] o_pin_change_src, g, e_oe;
    logic i_mcu_input_en, i_pin_change_group0_enable, i_two_wire_enable, i_spi_enable_bit;
    logic i_spi_master_select, i_timer0_compare_b_pin_en, i_two_wire_clock_out;
    logic i_spi_clock_out, i_timer0_compare_b_out, o_pin7_slew_limit_en;
    logic o_pin7_spike_filter_en, o_timer1_capture_in, o_spi_clock_in, o_timer1_ext_clock_in;
    logic o_spi_slave_select_in, o_two_wire_clock_in, ms, sl, v7;
    logic [2:0] val;
    logic [31:0] seed = 32'h4fa2;
    int fail_count = 0;
    int checked = 0;
    always #2.5 i_clk = ~i_clk;
    paafo_port_a u_dut (.*);
    paafo_periph_model u_periph (.i_clk, .i_val(val),
        .o_levels({i_two_wire_clock_out, i_spi_clock_out, i_timer0_compare_b_out}));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic drive();
        seed = xs(seed);
        {i_port_dir, i_port_out, i_pullup_en, i_pad_in} = seed;
        seed = xs(seed);
        {i_pin_change_mask, i_adc_input_disable, i_mcu_input_en, i_pin_change_group0_enable,
         i_spi_enable_bit, i_spi_master_select, i_timer0_compare_b_pin_en, val} = seed[23:0];
        i_two_wire_enable = &seed[31:30];
    endtask : drive
    task automatic check_all();
        ms = i_spi_enable_bit & i_spi_master_select;
        sl = i_spi_enable_bit & ~i_spi_master_select;
        e_oe = {i_two_wire_enable ? ~i_two_wire_clock_out : ~sl & i_port_dir[7],
                ~sl & i_port_dir[6], i_port_dir[5:0]};
        v7 = (i_two_wire_enable | ms | i_timer0_compare_b_pin_en) ? ~i_two_wire_enable &
             (ms ? i_spi_clock_out : i_timer0_compare_b_out) : i_port_out[7];
        g = i_pin_change_mask & {8{i_pin_change_group0_enable}};
        g = g | ~i_adc_input_disable & {8{i_mcu_input_en}};
        chk("input_en", o_pad_input_en, g);
        g = g & i_pad_in;
        chk("oe", o_pad_oe, e_oe);
        chk("out", o_pad_out, e_oe & {v7, i_port_out[6:0]});
        chk("pullup", o_pad_pullup, i_pullup_en);
        chk("slew", {o_pin7_slew_limit_en, o_pin7_spike_filter_en}, {2{i_two_wire_enable}});
        chk("pin_change", o_pin_change_src, g);
        chk("p7", {o_timer1_capture_in, o_timer1_ext_clock_in, o_spi_clock_in}, {3{g[7]}});
        chk("ss_in", o_spi_slave_select_in, g[6]);
        if (!i_two_wire_enable) begin
            chk("tw_in", o_two_wire_clock_in, g[7]);
        end
    endtask : check_all
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out
    initial begin
        drive();
        repeat (3) @(negedge i_clk);
        i_reset = 1'b0;
        chk("reset", o_pad_oe | o_pad_out | o_pad_input_en, 8'h00);
        $display("reset test done");
        i_two_wire_enable = 1'b1;
        i_mcu_input_en = 1'b1;
        i_adc_input_disable = 8'h00;
        i_pad_in[7] = 1'b0;
        repeat (20) @(negedge i_clk);
        i_pad_in[7] = 1'b1;
        for (int i = 0; i < 30; i++) begin
            @(negedge i_clk);
            i_pad_in[7] = i < 7;
            chk("spike", o_two_wire_clock_in, 1'b0);
        end
        i_pad_in[7] = 1'b1;
        repeat (20) @(negedge i_clk);
        chk("filter_pass", o_two_wire_clock_in, 1'b1);
        $display("spike test done");
        for (int i = 0; i < 300; i++) begin
            drive();
            repeat (6) @(negedge i_clk);
            check_all();
        end
        $display("random test done");
        close_out();
    end
    // about 1900 cycles of tests, allowed twice that
    initial begin
        #20000;
        fail_count++;
        close_out();
    end
endmodule : paafo_port_a_bench
